// ===== hdl/pcr_clock_restart.sv
`timescale 1ns/1ps
module pcr_clock_restart #(
  parameter int IRQ_W = pcr_pkg::IRQ_WIDTH,
  parameter int DRQ_W = pcr_pkg::DRQ_WIDTH
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             clkrun_i,
  output logic                  clkrun_o,
  output logic                  clkrun_oe_o,
  input  wire logic             clock_restart_enable_i,
  input  wire logic [IRQ_W-1:0] irq_i,
  input  wire logic [DRQ_W-1:0] drq_i,
  input  wire logic             delivered_i,
  output logic                  serial_irq_enable_o,
  output logic                  serial_irq_drive_ok_o,
  output logic                  dma_request_drive_ok_o,
  output logic                  pending_o
);
  import pcr_pkg::*;

  pcr_trig_if trig ();

  pcr_state_t state_reg;
  pcr_state_t state_next;
  logic [1:0] high_cnt_reg;
  logic [1:0] high_cnt_next;
  logic       running_reg;
  logic       running_next;
  logic       armed;
  logic       request;
  logic       start;

  pcr_trigger_detect #(
    .IRQ_W (IRQ_W),
    .DRQ_W (DRQ_W)
  ) pcr_trigger_detect_i (
    .clk_i  (clk_i),
    .srst_i (srst_i),
    .irq_i  (irq_i),
    .drq_i  (drq_i),
    .trig   (trig)
  );

  assign trig.enable    = clock_restart_enable_i;
  assign trig.delivered = delivered_i;

  ////////////////////////////////////////////////////////////////////////////
  // start is combinational so the pull-down begins without a clock edge
  // live line not read here: our own pull would feed back and ring;
  // armed already says the last two samples were high
  assign armed   = (high_cnt_reg == ARM_COUNT);
  assign request = trig.change | trig.pending;
  assign start   = clock_restart_enable_i && request && armed
                   && (state_reg == PCR_IDLE) && !srst_i;

  assign clkrun_o    = LINE_LOW;
  assign clkrun_oe_o = clock_restart_enable_i && !srst_i
                       && (start || (state_reg == PCR_DRIVE));

  // frames wait until the line was seen low, i.e. clock is running
  assign serial_irq_enable_o    = clock_restart_enable_i;
  assign serial_irq_drive_ok_o  = clock_restart_enable_i && running_reg;
  assign dma_request_drive_ok_o = clock_restart_enable_i && running_reg;
  assign pending_o              = trig.pending;

  always_comb begin
    state_next    = state_reg;
    high_cnt_next = high_cnt_reg;
    running_next  = !clkrun_i;
    if (!clkrun_i) begin
      high_cnt_next = 2'h0;
    end else if (high_cnt_reg != ARM_COUNT) begin
      high_cnt_next = high_cnt_reg + 2'h1;
    end
    unique case (state_reg)
      PCR_IDLE: begin
        if (start) begin
          state_next = PCR_DRIVE;
        end
      end
      PCR_DRIVE: begin
        state_next = PCR_IDLE;
      end
    endcase
    if (srst_i) begin
      state_next    = PCR_IDLE;
      high_cnt_next = 2'h0;
      running_next  = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    state_reg    <= state_next;
    high_cnt_reg <= high_cnt_next;
    running_reg  <= running_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence s_drive_window;
    (state_reg == PCR_DRIVE) ##1 (state_reg == PCR_IDLE);
  endsequence

  sequence s_pull_then_hold;
    clkrun_oe_o ##1 (state_reg == PCR_DRIVE);
  endsequence

  // two idle edges after release: the line must be seen high afresh
  sequence s_quiet_two;
    !clkrun_oe_o ##1 !clkrun_oe_o;
  endsequence

  property p_hold_two_edges;
    @(posedge clk_i) disable iff (srst_i)
      start |=> s_drive_window;
  endproperty
  a_hold_two_edges: assert property (p_hold_two_edges)
    else $error("clock-run not held for two edges");

  property p_disabled_quiet;
    @(posedge clk_i) disable iff (srst_i)
      !clock_restart_enable_i |-> !clkrun_oe_o && !serial_irq_drive_ok_o;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("drive while restart disabled");

  property p_seen_high_twice;
    @(posedge clk_i) disable iff (srst_i)
      (clkrun_oe_o && state_reg == PCR_IDLE) |-> $past(clkrun_i) && $past(clkrun_i, 2);
  endproperty
  a_seen_high_twice: assert property (p_seen_high_twice)
    else $error("line pulled without two high samples");

  property p_not_when_low;
    @(posedge clk_i) disable iff (srst_i)
      (clkrun_oe_o && state_reg == PCR_IDLE) |-> $past(clkrun_i);
  endproperty
  a_not_when_low: assert property (p_not_when_low)
    else $error("line pulled while already low");

  property p_request_pulls;
    @(posedge clk_i) disable iff (srst_i)
      (clock_restart_enable_i && trig.pending && armed
       && state_reg == PCR_IDLE) |-> s_pull_then_hold;
  endproperty
  a_request_pulls: assert property (p_request_pulls)
    else $error("pending request did not pull line");

  property p_frame_after_run;
    @(posedge clk_i) disable iff (srst_i)
      serial_irq_drive_ok_o |-> !$past(clkrun_i);
  endproperty
  a_frame_after_run: assert property (p_frame_after_run)
    else $error("serial irq allowed while clock stopped");

  property p_open_drain;
    @(posedge clk_i) disable iff (srst_i)
      clkrun_oe_o |-> (clkrun_o == LINE_LOW);
  endproperty
  a_open_drain: assert property (p_open_drain)
    else $error("clock-run driven high");

  property p_reset_release;
    @(posedge clk_i)
      srst_i |-> !clkrun_oe_o ##1 (!pending_o && state_reg == PCR_IDLE);
  endproperty
  a_reset_release: assert property (p_reset_release)
    else $error("reset did not release line");

  ////////////////////////////////////////////////////////////////////////////
  property p_change_pulls;
    @(posedge clk_i) disable iff (srst_i)
      (trig.change && armed && state_reg == PCR_IDLE) |-> s_pull_then_hold;
  endproperty
  a_change_pulls: assert property (p_change_pulls)
    else $error("change did not pull line");

  property p_drive_holds;
    @(posedge clk_i) disable iff (srst_i)
      (state_reg == PCR_DRIVE && clock_restart_enable_i) |-> clkrun_oe_o;
  endproperty
  a_drive_holds: assert property (p_drive_holds)
    else $error("line released before second edge");

  property p_rearm_gap;
    @(posedge clk_i) disable iff (srst_i)
      (state_reg == PCR_DRIVE && clock_restart_enable_i) |=> s_quiet_two;
  endproperty
  a_rearm_gap: assert property (p_rearm_gap)
    else $error("line pulled again without fresh high samples");

  property p_low_disarms;
    @(posedge clk_i) disable iff (srst_i)
      !clkrun_i |=> !armed;
  endproperty
  a_low_disarms: assert property (p_low_disarms)
    else $error("low sample did not disarm");

  property p_needs_trigger;
    @(posedge clk_i) disable iff (srst_i)
      (clkrun_oe_o && state_reg == PCR_IDLE) |-> (trig.change || trig.pending);
  endproperty
  a_needs_trigger: assert property (p_needs_trigger)
    else $error("line pulled with no trigger");

  property p_pending_held;
    @(posedge clk_i) disable iff (srst_i)
      (pending_o && !delivered_i && clock_restart_enable_i) |=> pending_o;
  endproperty
  a_pending_held: assert property (p_pending_held)
    else $error("pending dropped before delivery");

  property p_dma_after_run;
    @(posedge clk_i) disable iff (srst_i)
      dma_request_drive_ok_o |-> !$past(clkrun_i);
  endproperty
  a_dma_after_run: assert property (p_dma_after_run)
    else $error("dma request allowed while clock stopped");

  property p_disabled_outputs;
    @(posedge clk_i) disable iff (srst_i)
      !clock_restart_enable_i |-> !serial_irq_enable_o && !dma_request_drive_ok_o;
  endproperty
  a_disabled_outputs: assert property (p_disabled_outputs)
    else $error("serial irq or dma support left on while disabled");

  // no disable here: this one is about reset itself
  property p_reset_no_drive_ok;
    @(posedge clk_i)
      srst_i |=> !serial_irq_drive_ok_o && !dma_request_drive_ok_o;
  endproperty
  a_reset_no_drive_ok: assert property (p_reset_no_drive_ok)
    else $error("drive ok set after reset edge");

endmodule

// ===== hdl/pcr_pkg.sv
package pcr_pkg;

  localparam int          IRQ_WIDTH = 16;
  localparam int          DRQ_WIDTH = 4;
  // consecutive high samples needed before the line may be pulled
  localparam logic [1:0]  ARM_COUNT = 2'h2;
  localparam logic        LINE_LOW  = 1'h0;

  // two edges of hold: start edge enters drive, next edge leaves it
  typedef enum logic {
    PCR_IDLE  = 1'b0,
    PCR_DRIVE = 1'b1
  } pcr_state_t;

endpackage

// ===== hdl/pcr_trig_if.sv
`timescale 1ns/1ps
interface pcr_trig_if;
  logic change;
  logic pending;
  logic delivered;
  logic enable;

  modport det (
    output change,
    output pending,
    input  delivered,
    input  enable
  );

  modport ctl (
    input  change,
    input  pending,
    output delivered,
    output enable
  );
endinterface

// ===== hdl/pcr_trigger_detect.sv
`timescale 1ns/1ps
module pcr_trigger_detect #(
  parameter int IRQ_W = pcr_pkg::IRQ_WIDTH,
  parameter int DRQ_W = pcr_pkg::DRQ_WIDTH
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic [IRQ_W-1:0] irq_i,
  input  wire logic [DRQ_W-1:0] drq_i,
  pcr_trig_if.det               trig
);
  import pcr_pkg::*;

  logic [IRQ_W-1:0] irq_last_reg;
  logic [IRQ_W-1:0] irq_last_next;
  logic [DRQ_W-1:0] drq_last_reg;
  logic [DRQ_W-1:0] drq_last_next;
  logic             pending_reg;
  logic             pending_next;
  logic             change;

  ////////////////////////////////////////////////////////////////////////////
  // compared against last snapshot combinationally: an irq change or a drq rise shows even while
  // the clock is stopped, since the snapshot cannot move without edges
  assign change       = (|(irq_i ^ irq_last_reg)) | (|(drq_i & ~drq_last_reg));
  assign trig.change  = change & trig.enable;
  assign trig.pending = pending_reg;

  always_comb begin
    irq_last_next = irq_i;
    drq_last_next = drq_i;
    pending_next  = pending_reg;
    if (trig.delivered) begin
      pending_next = 1'b0;
    end
    if (change && trig.enable) begin
      pending_next = 1'b1;
    end
    if (!trig.enable) begin
      pending_next = 1'b0;
    end
    if (srst_i) begin
      irq_last_next = '0;
      drq_last_next = '0;
      pending_next  = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    irq_last_reg <= irq_last_next;
    drq_last_reg <= drq_last_next;
    pending_reg  <= pending_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_change_sets_pending;
    @(posedge clk_i) disable iff (srst_i)
      (change && trig.enable) |=> pending_reg;
  endproperty
  a_change_sets_pending: assert property (p_change_sets_pending)
    else $error("trigger did not set pending");

  property p_delivery_clears;
    @(posedge clk_i) disable iff (srst_i)
      (trig.delivered && !change && pending_reg) |=> !pending_reg;
  endproperty
  a_delivery_clears: assert property (p_delivery_clears)
    else $error("delivery did not clear pending");

endmodule

// ===== verif/pcr_clock_gen_model.sv
`timescale 1ns/1ps
// far-side clock generator: holds the line low while the clock runs
module pcr_clock_gen_model (
  input  wire logic clk_i,
  input  wire logic srst_i,
  input  wire logic stop_i,
  input  wire logic dev_i,
  input  wire logic dev_oe_i,
  output logic      line_o
);
  logic run_reg;
  always_ff @(posedge clk_i) begin
    // a request seen low restarts the clock, as the real generator does
    if (srst_i || (!line_o && !stop_i)) begin
      run_reg <= 1'b1;
    end else if (stop_i) begin
      run_reg <= 1'b0;
    end
  end
  // wired-and with pull-up; released line reads high
  assign line_o = !(run_reg || (dev_oe_i && !dev_i));
endmodule

// ===== verif/pcr_clock_restart_tb.sv
`timescale 1ns/1ps
module pcr_clock_restart_tb;
  logic clk, srst, en, dlv, stop, line, oe, dout, sen, sok, dok, pend;
  logic [15:0] irq;
  logic [3:0]  drq;
  int err_total, samples_checked;
  ////////////////////////////////////////////////////////////////
  pcr_clock_restart pcr_clock_restart_i (
    .clk_i(clk), .srst_i(srst), .clkrun_i(line), .clkrun_o(dout),
    .clkrun_oe_o(oe), .clock_restart_enable_i(en), .irq_i(irq), .drq_i(drq),
    .delivered_i(dlv), .serial_irq_enable_o(sen), .serial_irq_drive_ok_o(sok),
    .dma_request_drive_ok_o(dok), .pending_o(pend));
  pcr_clock_gen_model pcr_clock_gen_model_i (
    .clk_i(clk), .srst_i(srst), .stop_i(stop), .dev_i(dout), .dev_oe_i(oe),
    .line_o(line));
  ////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic chk(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("checks=%0d errors=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic nclk(input int n);
    repeat (n) @(negedge clk);
  endtask
  // stop clock, then let two high samples arm the device
  task automatic stop_armed;
    nclk(1); stop = 1'b1;
    nclk(1); stop = 1'b0;
    nclk(2);
  endtask
  task automatic deliver;
    nclk(1); dlv = 1'b1;
    nclk(1); dlv = 1'b0;
    #1 chk(pend, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_running;
    nclk(1); irq[0] = 1'b1;
    #1 chk(oe, 1'b0);
    chk(sok, 1'b1);
    chk(dok, 1'b1);
    chk(sen, 1'b1);
    deliver();
  endtask
  task automatic t_irq;
    nclk(1); stop = 1'b1;
    nclk(1); stop = 1'b0;
    nclk(1); irq[3] = 1'b1;
    #1 chk(oe, 1'b0);
    chk(sok, 1'b0);
    nclk(1); #1 chk(oe, 1'b1);
    chk(dout, 1'b0);
    nclk(1); #1 chk(oe, 1'b1);
    chk(sok, 1'b1);
    nclk(1); #1 chk(oe, 1'b0);
    stop_armed();
    #1 chk(oe, 1'b1);
    deliver();
  endtask
  task automatic t_drq;
    stop_armed(); drq[1] = 1'b1;
    #1 chk(oe, 1'b1);
    chk(dok, 1'b0);
    deliver();
    stop_armed(); drq[1] = 1'b0;
    #1 chk(oe, 1'b0);
    nclk(1); #1 chk(pend, 1'b0);
  endtask
  task automatic t_disable;
    nclk(1); en = 1'b0;
    #1 chk(sen, 1'b0);
    nclk(2); irq[5] = 1'b1;
    #1 chk(oe, 1'b0);
    nclk(1); #1 chk(pend, 1'b0);
    nclk(1); en = 1'b1;
  endtask
  // snapshot clears in reset, so nonzero irqs at release count as a change
  task automatic t_reset;
    nclk(1); srst = 1'b1; irq[7] = 1'b1;
    #1 chk(oe, 1'b0);
    nclk(2); #1 chk(pend, 1'b0);
    nclk(1); srst = 1'b0;
    #1 chk(oe, 1'b0);
    nclk(1); #1 chk(pend, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    {srst, en, dlv, stop, irq, drq} = {4'b1100, 16'h0000, 4'h0};
    err_total = 0;
    samples_checked = 0;
    nclk(3); srst = 1'b0;
    t_running(); t_irq(); t_drq(); t_disable(); t_reset();
    final_report();
  end
  // a hang after about four times the expected run ends the test
  initial begin
    repeat (160) @(posedge clk);
    err_total++;
    final_report();
  end
endmodule
